// ==== inc/pllcs_pkg.sv ====
// Purpose: shared constants and types for the core clock source selector
// Assumes: one 125 MHz clock; clocks are modelled as one-cycle half-period ticks
// Notes:   widths here set the reach of the period meter and the multiplier
package pllcs_pkg;

    // Clock rate
    localparam int unsigned MCLK_PERIOD_NS = 8;
    localparam int unsigned MCLK_MHZ       = 1000 / MCLK_PERIOD_NS;

    // Instruction cycle structure
    localparam int unsigned SRC_DIVIDE     = 2;    // source periods per instruction cycle
    localparam int unsigned PHASE_COUNT    = 2 * SRC_DIVIDE;
    localparam int unsigned PHASE_W        = $clog2(PHASE_COUNT);
    localparam logic [1:0]  PHASE_FIRST    = 2'h0;
    localparam logic [1:0]  PHASE_LAST     = 2'h3;

    // Multiplier and period meter
    localparam int unsigned MULT_W         = 6;
    localparam logic [5:0]  MULT_RESET     = 6'h01;
    localparam int unsigned PERIOD_W       = 12;

    // Source selection after reset
    localparam logic        SEL_EXT        = 1'b0;
    localparam logic        SEL_PLL        = 1'b1;

    typedef enum {
        PLLCS_SW_RUN,
        PLLCS_SW_WAIT
    } pllcs_sw_e;

    // Bundle of internal core clock signals
    typedef struct packed {
        logic               src_clk;     // internal processor clock level
        logic               instr_clk;   // instruction cycle clock level
        logic [1:0]         phase;       // current phase 0..3
        logic               cycle_start; // one-cycle pulse at phase 0 entry
        logic               from_pll;    // active source is the multiplier
    } pllcs_core_s;

endpackage

// ==== core/pllcs_vco.sv ====
// Purpose: digital stand-in for the oscillator; multiplies the reference rate
// Assumes: ext_rise is a one-cycle pulse per reference period, already synchronised
// Notes:   emits at most one half-period tick per mclk, so 2*mult must stay below period
`timescale 1ns/1ns
module pllcs_vco #(
    parameter int unsigned PERIOD_W = pllcs_pkg::PERIOD_W,
    parameter int unsigned MULT_W   = pllcs_pkg::MULT_W
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic                ext_rise,
    input  wire logic [MULT_W-1:0]   mult,
    output logic                     half_tick,
    output logic                     locked
);

    localparam int unsigned ACC_W = PERIOD_W + MULT_W + 2;

    logic [PERIOD_W-1:0] cnt;
    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] prev_period;
    logic [ACC_W-1:0]    acc;
    logic [PERIOD_W-1:0] next_cnt;
    logic [PERIOD_W-1:0] next_period;
    logic [PERIOD_W-1:0] next_prev_period;
    logic [ACC_W-1:0]    next_acc;
    logic                next_half_tick;
    logic                next_locked;
    logic [ACC_W-1:0]    sum;

    // Period meter and phase accumulator; two equal periods count as lock
    always_comb begin
        next_cnt         = cnt + 1'b1;
        next_period      = period;
        next_prev_period = prev_period;
        sum              = acc + ACC_W'({mult, 1'b0});
        next_acc         = acc;
        next_half_tick   = 1'b0;
        if (ext_rise) begin
            next_cnt         = '0;
            next_period      = cnt + 1'b1;
            next_prev_period = period;
        end
        if (period != '0) begin
            if (sum >= ACC_W'(period)) begin
                next_acc       = sum - ACC_W'(period);
                next_half_tick = 1'b1;
            end else begin
                next_acc = sum;
            end
        end
        next_locked = (period != '0) && (period == prev_period);
    end

    // Registers only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt         <= '0;
            period      <= '0;
            prev_period <= '0;
            acc         <= '0;
            half_tick   <= 1'b0;
            locked      <= 1'b0;
        end else begin
            cnt         <= next_cnt;
            period      <= next_period;
            prev_period <= next_prev_period;
            acc         <= next_acc;
            half_tick   <= next_half_tick;
            locked      <= next_locked;
        end
    end

    property p_tick_needs_ref;
        @(posedge mclk) disable iff (!rst_n)
        half_tick |-> $past(period) != '0;
    endproperty
    a_tick_needs_ref: assert property (p_tick_needs_ref) else $error("tick without reference period");

endmodule

// ==== core/pllcs_top.sv ====
// Purpose: picks the core clock source and forms the four-phase instruction clock
// Assumes: ext_clock_in and pll_init_pin are asynchronous pins; software controls are mclk-synchronous
// Notes:   clocks are ticks on mclk; the lock flag never leaves the core side
`timescale 1ns/1ns
module pllcs_top #(
    parameter int unsigned MULT_W   = pllcs_pkg::MULT_W,
    parameter int unsigned PERIOD_W = pllcs_pkg::PERIOD_W
) (
    input  wire logic               mclk,
    input  wire logic               arst_n,
    input  wire logic               ext_clock_in,
    input  wire logic               pll_init_pin,
    input  wire logic               sw_pen_wr,
    input  wire logic               sw_pen_data,
    input  wire logic [MULT_W-1:0]  pll_mult,
    output pllcs_pkg::pllcs_core_s  core,
    output logic                    pll_enable_bit,
    output logic                    pll_locked_int,
    output logic                    switch_busy
);

    logic [1:0]            rst_ff;
    logic                  rst_n;
    logic                  ext_s1;
    logic                  ext_s2;
    logic                  ext_d;
    logic                  init_s1;
    logic                  init_s2;
    logic                  ext_edge;
    logic                  ext_rise;
    logic                  vco_tick;
    logic                  vco_locked;
    logic                  next_pen;
    pllcs_pkg::pllcs_sw_e  sw_state;
    pllcs_pkg::pllcs_sw_e  next_sw_state;
    logic                  sel;
    logic                  next_sel;
    logic                  swap;
    logic                  src_tick;
    logic                  adv;
    logic [1:0]            phase;
    logic [1:0]            next_phase;
    logic                  cycle_start;
    logic                  next_cycle_start;

    // Reset release through two flops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_ff <= 2'h0;
        end else begin
            rst_ff <= {rst_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_ff[1];

    // Pin synchronisers; ext_d only ever sees the second stage
    // No reset: the stages track the pin through reset, so release shows no false edge
    always_ff @(posedge mclk) begin
        ext_s1 <= ext_clock_in;
        ext_s2 <= ext_s1;
        ext_d  <= ext_s2;
    end

    // Init pin synchroniser has no reset so it tracks the strap during reset
    always_ff @(posedge mclk) begin
        init_s1 <= pll_init_pin;
        init_s2 <= init_s1;
    end

    // Both edges are half periods of the reference
    assign ext_edge = ext_s2 ^ ext_d;
    assign ext_rise = ext_s2 & ~ext_d;

    // Multiplier stand-in, fed from the reference only
    pllcs_vco #(
        .PERIOD_W (PERIOD_W),
        .MULT_W   (MULT_W)
    ) u_vco (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ext_rise  (ext_rise),
        .mult      (pll_mult),
        .half_tick (vco_tick),
        .locked    (vco_locked)
    );

    // Enable bit: strap during reset, software after it
    always_comb begin
        if (!rst_n) begin
            next_pen = init_s2;
        end else if (sw_pen_wr) begin
            next_pen = sw_pen_data;
        end else begin
            next_pen = pll_enable_bit;
        end
    end

    // No reset: a constant here would lose the strap
    always_ff @(posedge mclk) begin
        pll_enable_bit <= next_pen;
    end

    // Swap only between instruction cycles, and onto a locked multiplier
    assign swap = (sw_state == pllcs_pkg::PLLCS_SW_WAIT) && (phase == pllcs_pkg::PHASE_FIRST)
                  && (!pll_enable_bit || vco_locked);

    // Selected half-period tick; a swap cycle drops the old source's tick
    assign src_tick = sel ? vco_tick : ext_edge;
    assign adv      = src_tick && !swap;

    // Source switch state machine
    always_comb begin
        next_sw_state = sw_state;
        next_sel      = sel;
        case (sw_state)
            pllcs_pkg::PLLCS_SW_RUN: begin
                if (pll_enable_bit != sel) begin
                    next_sw_state = pllcs_pkg::PLLCS_SW_WAIT;
                end
            end
            pllcs_pkg::PLLCS_SW_WAIT: begin
                if (pll_enable_bit == sel) begin
                    next_sw_state = pllcs_pkg::PLLCS_SW_RUN;
                end else if (swap) begin
                    next_sel      = pll_enable_bit;
                    next_sw_state = pllcs_pkg::PLLCS_SW_RUN;
                end
            end
            default: begin
                next_sw_state = pllcs_pkg::PLLCS_SW_RUN;
            end
        endcase
    end

    // Phase counter: four half periods make one instruction cycle
    always_comb begin
        next_phase       = phase;
        next_cycle_start = 1'b0;
        if (adv) begin
            next_phase       = 2'(phase + 2'h1);
            next_cycle_start = (phase == pllcs_pkg::PHASE_LAST);
        end
    end

    // Source comes up on the external input; the state machine moves it later
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sw_state    <= pllcs_pkg::PLLCS_SW_RUN;
            sel         <= pllcs_pkg::SEL_EXT;
            phase       <= pllcs_pkg::PHASE_FIRST;
            cycle_start <= 1'b0;
        end else begin
            sw_state    <= next_sw_state;
            sel         <= next_sel;
            phase       <= next_phase;
            cycle_start <= next_cycle_start;
        end
    end

    // Core-side outputs only; nothing here reaches a pin
    assign core.src_clk     = ~phase[0];
    assign core.instr_clk   = ~phase[1];
    assign core.phase       = phase;
    assign core.cycle_start = cycle_start;
    assign core.from_pll    = sel;
    assign pll_locked_int   = vco_locked;
    assign switch_busy      = (sw_state == pllcs_pkg::PLLCS_SW_WAIT);

    // Checks
    sequence s_pll_step;
        sel && vco_tick && !swap;
    endsequence

    sequence s_ext_step;
        !sel && ext_edge && !swap;
    endsequence

    property p_init_copy;
        @(posedge mclk) disable iff (!arst_n)
        !rst_n |=> pll_enable_bit == $past(init_s2);
    endproperty
    a_init_copy: assert property (p_init_copy) else $error("strap not copied in reset");

    property p_pin_ignored;
        @(posedge mclk) disable iff (!rst_n)
        !sw_pen_wr ##1 rst_n |-> pll_enable_bit == $past(pll_enable_bit);
    endproperty
    a_pin_ignored: assert property (p_pin_ignored) else $error("enable bit moved without write");

    property p_pll_step;
        @(posedge mclk) disable iff (!rst_n)
        s_pll_step |=> phase == 2'($past(phase) + 2'h1);
    endproperty
    a_pll_step: assert property (p_pll_step) else $error("oscillator tick not counted");

    property p_ext_step;
        @(posedge mclk) disable iff (!rst_n)
        s_ext_step |=> phase == 2'($past(phase) + 2'h1);
    endproperty
    a_ext_step: assert property (p_ext_step) else $error("external edge not counted");

    property p_no_stray_step;
        @(posedge mclk) disable iff (!rst_n)
        !src_tick |=> $stable(phase);
    endproperty
    a_no_stray_step: assert property (p_no_stray_step) else $error("phase moved without tick");

    property p_cycle_end;
        @(posedge mclk) disable iff (!rst_n)
        (phase == pllcs_pkg::PHASE_LAST) && adv |=> cycle_start && phase == pllcs_pkg::PHASE_FIRST;
    endproperty
    a_cycle_end: assert property (p_cycle_end) else $error("instruction cycle not four phases");

    property p_swap_boundary;
        @(posedge mclk) disable iff (!rst_n)
        rst_n && $changed(sel) |-> phase == pllcs_pkg::PHASE_FIRST && $past(sw_state) == pllcs_pkg::PLLCS_SW_WAIT;
    endproperty
    a_swap_boundary: assert property (p_swap_boundary) else $error("source swapped mid cycle");

    property p_pll_locked_on_entry;
        @(posedge mclk) disable iff (!rst_n)
        $rose(sel) |-> $past(vco_locked);
    endproperty
    a_pll_locked_on_entry: assert property (p_pll_locked_on_entry) else $error("swap to unlocked multiplier");

endmodule

// ==== verification/pllcs_ref_src.sv ====
// Purpose: reference clock source standing at the far side of the selector
// Assumes: half period given in mclk cycles, at least 2
// Notes:   changes only on the falling edge, like the rest of the stimulus
`timescale 1ns/1ns
module pllcs_ref_src (
    input  wire logic       mclk,
    input  wire logic       run,
    input  wire logic [7:0] half_cyc,
    output logic            ext_clock_in
);
    logic [7:0] cnt;

    // Free-running square wave; holds level while stopped
    initial begin
        cnt          = 8'h00;
        ext_clock_in = 1'b0;
    end
    always @(negedge mclk) begin
        if (run) begin
            if (cnt >= half_cyc - 8'h01) begin
                cnt          <= 8'h00;
                ext_clock_in <= ~ext_clock_in;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule

// ==== verification/pllcs_top_tb_top.sv ====
// Purpose: self-checking bench for the core clock source selector
// Assumes: reference half period 16 cycles, so one reference period is 32 cycles
// Notes:   cycle counts are compared with one pulse of slack for window edges
`timescale 1ns/1ns
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin fails++; \
    $display("ERROR %0t: value mismatch", $time); end end
module pllcs_top_tb_top;
    logic                   mclk;
    logic                   arst_n;
    logic                   pll_init_pin;
    logic                   sw_pen_wr;
    logic                   sw_pen_data;
    logic [5:0]             pll_mult;
    logic                   ext_clock_in;
    pllcs_pkg::pllcs_core_s core;
    logic                   pll_enable_bit;
    logic                   pll_locked_int;
    logic                   switch_busy;
    logic [1:0]             prev_phase;
    int                     fails;
    int                     samples_checked;
    int                     bad_steps;

    pllcs_ref_src u_ref (
        .mclk         (mclk),
        .run          (1'b1),
        .half_cyc     (8'h10),
        .ext_clock_in (ext_clock_in)
    );

    pllcs_top uut (
        .mclk           (mclk),
        .arst_n         (arst_n),
        .ext_clock_in   (ext_clock_in),
        .pll_init_pin   (pll_init_pin),
        .sw_pen_wr      (sw_pen_wr),
        .sw_pen_data    (sw_pen_data),
        .pll_mult       (pll_mult),
        .core           (core),
        .pll_enable_bit (pll_enable_bit),
        .pll_locked_int (pll_locked_int),
        .switch_busy    (switch_busy)
    );

    // Clock at 8 ns
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Phase may only step by one; a skip or jump means a runt across a swap
    always @(posedge mclk) begin
        if (arst_n && core.phase !== prev_phase && core.phase !== prev_phase + 2'h1) begin
            bad_steps++;
        end
        prev_phase <= core.phase;
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hardware reset with a given strap level, 12 cycles low
    task automatic do_reset(input logic strap);
        @(negedge mclk);
        pll_init_pin = strap;
        arst_n       = 1'b0;
        repeat (12) @(negedge mclk);
        arst_n = 1'b1;
        repeat (4) @(negedge mclk);
    endtask

    // Count instruction cycle starts over a fixed window
    task automatic count_starts(input int win, input int lo, input int hi);
        int n;
        n = 0;
        repeat (win) begin
            @(negedge mclk);
            if (core.cycle_start === 1'b1) n++;
        end
        `CHK(n >= lo && n <= hi, 1'b1)
    endtask

    // Bounded wait for the active source to become the wanted one
    task automatic wait_src(input logic want);
        int i;
        for (i = 0; i < 2000 && core.from_pll !== want; i++) @(negedge mclk);
        if (core.from_pll !== want) begin
            fails++;
            $display("ERROR %0t: source swap timed out", $time);
            print_verdict();
        end
    endtask

    // Clock levels from the start of an instruction cycle into its second phase
    task automatic check_clocks();
        int i;
        for (i = 0; i < 200 && core.cycle_start !== 1'b1; i++) @(negedge mclk);
        `CHK(core.cycle_start, 1'b1)
        `CHK(core.phase, pllcs_pkg::PHASE_FIRST)
        `CHK(core.src_clk, 1'b1)
        `CHK(core.instr_clk, 1'b1)
        for (i = 0; i < 200 && core.phase === pllcs_pkg::PHASE_FIRST; i++) @(negedge mclk);
        `CHK(core.src_clk, 1'b0)
        `CHK(core.instr_clk, 1'b1)
    endtask

    task automatic sw_write(input logic d);
        @(negedge mclk);
        sw_pen_wr   = 1'b1;
        sw_pen_data = d;
        @(negedge mclk);
        sw_pen_wr = 1'b0;
        `CHK(pll_enable_bit, d)
    endtask

    // Strap low: external source, pin ignored after reset
    task automatic scen_ext_source();
        do_reset(1'b0);
        `CHK(pll_enable_bit, 1'b0)
        `CHK(pll_locked_int, 1'b0)
        pll_init_pin = 1'b1;
        repeat (20) @(negedge mclk);
        `CHK(pll_enable_bit, 1'b0)
        `CHK(core.from_pll, 1'b0)
        // 64 cycles per instruction: two reference periods
        count_starts(640, 9, 11);
        check_clocks();
    endtask

    // Strap high: oscillator drives the phases at the programmed rate
    task automatic scen_pll_source();
        pll_mult = 6'h02;
        do_reset(1'b1);
        `CHK(pll_enable_bit, 1'b1)
        pll_init_pin = 1'b0;
        wait_src(1'b1);
        `CHK(pll_enable_bit, 1'b1)
        `CHK(pll_locked_int, 1'b1)
        // Factor 2: 4 half ticks per 32-cycle reference period, one instruction each
        count_starts(640, 19, 21);
        pll_mult = 6'h04;
        repeat (300) @(negedge mclk);
        // Factor 4: instruction every 16 cycles
        count_starts(640, 39, 41);
        check_clocks();
    endtask

    // Software swaps both ways; after a write taken back two cycles later the source must be external again 200 cycles on
    task automatic scen_sw_switch();
        sw_write(1'b0);
        @(negedge mclk);
        `CHK(switch_busy, 1'b1)
        wait_src(1'b0);
        `CHK(switch_busy, 1'b0)
        count_starts(640, 9, 11);
        sw_write(1'b1);
        sw_write(1'b0);
        repeat (200) @(negedge mclk);
        `CHK(core.from_pll, 1'b0)
        sw_write(1'b1);
        wait_src(1'b1);
        `CHK(bad_steps, 0)
    endtask

    initial begin
        arst_n          = 1'b0;
        pll_init_pin    = 1'b0;
        sw_pen_wr       = 1'b0;
        sw_pen_data     = 1'b0;
        pll_mult        = 6'h01;
        prev_phase      = 2'h0;
        fails           = 0;
        samples_checked = 0;
        bad_steps       = 0;
        scen_ext_source();
        scen_pll_source();
        scen_sw_switch();
        print_verdict();
    end
endmodule
